/* inc/tqo_pkg.sv */
// Purpose: shared constants and types for the torque-off interlock block
// Assumes: 20 MHz core clock, plain register port with 8-bit byte address
// Notes: long counts are derived here and handed to top-level parameters
package tqo_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned NS_PER_MS = 1000000;
	localparam int unsigned CHK_SETTLE_NS = 100000;
	localparam int unsigned CHK_SETTLE_CYC = (CHK_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [11:0] CHK_CNT_MAX = 12'(CHK_SETTLE_CYC - 1);
	localparam logic [11:0] BOOT_CNT_MAX = 12'h002;
	localparam int unsigned STAT_PERIOD_MS = 2000;
	localparam int unsigned STAT_SLOTS = 16;
	localparam int unsigned COMM_FLASH_MS = 200;
	localparam int unsigned COMM_PULSE_MS = 40;
	localparam int unsigned CAN_HOLD_MS = 100;
	localparam int unsigned TOD_TICK_MS = 1000;

	function automatic int unsigned ms_to_cyc(input int unsigned ms);
		return ms * (NS_PER_MS / CLK_PERIOD_NS);
	endfunction

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATE = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h10;
	localparam logic [7:0] ADDR_TOD = 8'h14;
	localparam logic [7:0] ADDR_USER = 8'h18;
	localparam int unsigned CTRL_DRIVE_BIT = 0;
	localparam logic CTRL_DRIVE_RST = 1'b0;
	localparam logic [3:0] IRQ_EN_RST = 4'h0;

	localparam int unsigned EV_PASS = 0;
	localparam int unsigned EV_FAIL = 1;
	localparam int unsigned EV_TRIP = 2;
	localparam int unsigned EV_ARM = 3;
	localparam int unsigned EV_W = 4;

	localparam int unsigned SYN_GENERAL_INPUT_ONE = 0;
	localparam int unsigned SYN_GENERAL_INPUT_TWO = 1;
	localparam int unsigned SYN_JMP = 2;
	localparam int unsigned SYN_FB = 3;
	localparam int unsigned SYN_W = 4;

	typedef enum logic [5:0] {
		ST_BOOT = 6'h01,
		ST_CHK_OFF = 6'h02,
		ST_CHK_ON = 6'h04,
		ST_RUN = 6'h08,
		ST_STOP = 6'h10,
		ST_FAULT = 6'h20
	} tqo_state_e;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} tqo_bus_req_s;

	typedef struct packed {
		logic [1:0] blinks;
		logic red;
		logic steady;
	} tqo_stat_pat_s;
endpackage

/* rtl/tqo_led.sv */
// Purpose: status and communication indicator pattern generator
// Assumes: usb and can activity come from logic on the core clock
// Notes: status period is sixteen slots, a blink is one even slot
`timescale 1ns/10ps
module tqo_led #(
	parameter int unsigned SLOT_CYC = 2500000,
	parameter int unsigned FLASH_CYC = 4000000,
	parameter int unsigned PULSE_CYC = 800000,
	parameter int unsigned HOLD_CYC = 2000000
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input tqo_pkg::tqo_stat_pat_s i_pat,
	input wire logic i_usb_active,
	input wire logic i_can_activity,
	output logic o_led_stat_grn,
	output logic o_led_stat_red,
	output logic o_led_comm
);
	import tqo_pkg::*;

	logic [31:0] slot_cnt_r;
	logic [3:0] slot_r;
	logic [31:0] hold_cnt_r;
	logic [31:0] flash_cnt_r;
	logic stat_on;
	logic can_recent;
	logic pulse;

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			slot_cnt_r <= 32'h0;
			slot_r <= 4'h0;
		end
		else if (slot_cnt_r == 32'(SLOT_CYC - 1))
		begin
			slot_cnt_r <= 32'h0;
			slot_r <= slot_r + 4'h1;
		end
		else
			slot_cnt_r <= slot_cnt_r + 32'h1;
	end

	// blink n occupies even slots 0..2n-2 so the count is readable by eye
	assign stat_on = i_pat.steady || (!slot_r[0] && (slot_r[3:1] < {1'b0, i_pat.blinks}));

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_led_stat_grn <= 1'b0;
			o_led_stat_red <= 1'b0;
		end
		else
		begin
			o_led_stat_grn <= stat_on && !i_pat.red;
			o_led_stat_red <= stat_on && i_pat.red;
		end
	end

	// traffic is "present" for a hold time after the last frame
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			hold_cnt_r <= 32'h0;
		else if (i_can_activity)
			hold_cnt_r <= 32'(HOLD_CYC);
		else if (hold_cnt_r != 32'h0)
			hold_cnt_r <= hold_cnt_r - 32'h1;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			flash_cnt_r <= 32'h0;
		else if (flash_cnt_r == 32'(FLASH_CYC - 1))
			flash_cnt_r <= 32'h0;
		else
			flash_cnt_r <= flash_cnt_r + 32'h1;
	end

	assign can_recent = hold_cnt_r != 32'h0;
	assign pulse = flash_cnt_r < 32'(PULSE_CYC);

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_led_comm <= 1'b0;
		else
			o_led_comm <= i_usb_active ^ (can_recent && pulse);
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	comm_steady_a: assert property (!can_recent |=> o_led_comm == $past(i_usb_active))
		else $error("comm led not steady without can traffic");
	comm_flash_a: assert property (can_recent && pulse && !i_can_activity |=> o_led_comm != $past(i_usb_active))
		else $error("comm led missed its flash pulse");
	stat_colour_a: assert property (i_pat.red |=> !o_led_stat_grn)
		else $error("fault pattern shown in green");
endmodule

/* rtl/tqo_interlock.sv */
// Purpose: safe torque-off interlock, self-check, indicators, register port
// Assumes: single core clock; pins pass two flops; phase commands on core clock
// Notes: backup domain holds time and user word across main power loss
// Operation
// - with safe stop enabled, general inputs one and two become the stop inputs
// - power stage energized only while both stop inputs are high together
// - self-check of the stop circuit after every power-on before any drive
// - repeat the self-check whenever the stop inputs rise to both high
// - drive permitted only after the latest self-check passed
// - either stop input low disables all power-stage outputs at once
// - safe stop off by default; on only when the strap shows jumper removed
// - safe stop turns off all phase drive, motor floats, no braking
// - power indicator on continuously after power-on
// - status indicator flashes on a two second period showing state
// - no can traffic: comm indicator steady, off without usb, on with usb
// - can traffic: short on-pulses without usb, short off-pulses with usb
// - time counter and user word kept while main power is off
`timescale 1ns/10ps
module tqo_interlock #(
	parameter int unsigned STAT_SLOT_CYC = tqo_pkg::ms_to_cyc(tqo_pkg::STAT_PERIOD_MS) / tqo_pkg::STAT_SLOTS,
	parameter int unsigned COMM_FLASH_CYC = tqo_pkg::ms_to_cyc(tqo_pkg::COMM_FLASH_MS),
	parameter int unsigned COMM_PULSE_CYC = tqo_pkg::ms_to_cyc(tqo_pkg::COMM_PULSE_MS),
	parameter int unsigned CAN_HOLD_CYC = tqo_pkg::ms_to_cyc(tqo_pkg::CAN_HOLD_MS),
	parameter int unsigned TOD_TICK_CYC = tqo_pkg::ms_to_cyc(tqo_pkg::TOD_TICK_MS)
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_bkp_rstn,
	input tqo_pkg::tqo_bus_req_s i_bus,
	output logic [31:0] o_rdata,
	output logic o_irq,
	input wire logic i_general_input_one,
	input wire logic i_general_input_two,
	input wire logic i_jumper_fitted,
	input wire logic i_interlock_fb,
	input wire logic [2:0] i_phase_hi,
	input wire logic [2:0] i_phase_lo,
	input wire logic i_usb_active,
	input wire logic i_can_activity,
	output logic [2:0] o_gate_hi,
	output logic [2:0] o_gate_lo,
	output logic o_chk_pulse,
	output logic o_general_input_one,
	output logic o_general_input_two,
	output logic o_led_power,
	output logic o_led_stat_grn,
	output logic o_led_stat_red,
	output logic o_led_comm
);
	import tqo_pkg::*;

	tqo_state_e state_r, state_nxt;
	logic [SYN_W-1:0] sync1_r, sync2_r;
	logic both, both_q_r, both_rise, fb, safe_stop_en_r;
	logic [11:0] chk_cnt_r;
	logic chk_end, permit, drive_allow_r;
	logic [EV_W-1:0] ev, irq_stat_r, irq_en_r;
	logic [31:0] rdata_nxt, tod_r, user_r, tick_cnt_r;
	tqo_stat_pat_s pat;

	// first stage feeds only the second stage
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			sync1_r <= '0;
			sync2_r <= '0;
		end
		else
		begin
			sync1_r <= {i_interlock_fb, i_jumper_fitted, i_general_input_two, i_general_input_one};
			sync2_r <= sync1_r;
		end
	end

	assign both = sync2_r[SYN_GENERAL_INPUT_ONE] && sync2_r[SYN_GENERAL_INPUT_TWO];
	assign fb = sync2_r[SYN_FB];
	assign both_rise = both && !both_q_r;

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			both_q_r <= 1'b0;
		else
			both_q_r <= both;
	end

	// strap caught once the synchroniser has filled; never follows the pin after
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			safe_stop_en_r <= 1'b0;
		else if (state_r == ST_BOOT && chk_cnt_r == BOOT_CNT_MAX)
			safe_stop_en_r <= !sync2_r[SYN_JMP];
	end

	assign chk_end = chk_cnt_r == CHK_CNT_MAX;

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_BOOT:
				if (chk_cnt_r == BOOT_CNT_MAX)
					state_nxt = ST_CHK_OFF;
			ST_CHK_OFF:
				if (chk_end)
					state_nxt = fb ? ST_FAULT : ST_CHK_ON;
			ST_CHK_ON:
				if (chk_end && fb != (!safe_stop_en_r || both))
					state_nxt = ST_FAULT;
				else if (chk_end)
					state_nxt = (safe_stop_en_r && !both) ? ST_STOP : ST_RUN;
			ST_RUN:
				if (safe_stop_en_r && !both)
					state_nxt = ST_STOP;
			ST_STOP:
				if (both_rise)
					state_nxt = ST_CHK_OFF;
			ST_FAULT:
				if (safe_stop_en_r && both_rise)
					state_nxt = ST_CHK_OFF;
			default:
				state_nxt = ST_FAULT;
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			state_r <= ST_BOOT;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			chk_cnt_r <= 12'h000;
		else if (state_nxt != state_r)
			chk_cnt_r <= 12'h000;
		else if (state_r == ST_BOOT || state_r == ST_CHK_OFF || state_r == ST_CHK_ON)
			chk_cnt_r <= chk_cnt_r + 12'h001;
	end

	// test stimulus blocks the hardware path; feedback must then read low
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_chk_pulse <= 1'b0;
		else
			o_chk_pulse <= state_nxt == ST_CHK_OFF;
	end

	assign permit = state_r == ST_RUN && drive_allow_r && (!safe_stop_en_r || both);

	// all switches open, none closed low: the motor floats
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_gate_hi <= 3'h0;
			o_gate_lo <= 3'h0;
		end
		else if (permit)
		begin
			o_gate_hi <= i_phase_hi;
			o_gate_lo <= i_phase_lo;
		end
		else
		begin
			o_gate_hi <= 3'h0;
			o_gate_lo <= 3'h0;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_general_input_one <= 1'b0;
			o_general_input_two <= 1'b0;
		end
		else
		begin
			o_general_input_one <= sync2_r[SYN_GENERAL_INPUT_ONE] && !safe_stop_en_r;
			o_general_input_two <= sync2_r[SYN_GENERAL_INPUT_TWO] && !safe_stop_en_r;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_led_power <= 1'b0;
		else
			o_led_power <= 1'b1;
	end

	always_comb
	begin
		pat = '{blinks: 2'h0, red: 1'b0, steady: 1'b1};
		case (state_r)
			ST_RUN: pat = '{blinks: 2'h1, red: 1'b0, steady: 1'b0};
			ST_STOP: pat = '{blinks: 2'h2, red: 1'b0, steady: 1'b0};
			ST_FAULT: pat = '{blinks: 2'h3, red: 1'b1, steady: 1'b0};
			default: pat = '{blinks: 2'h0, red: 1'b0, steady: 1'b1};
		endcase
	end

	tqo_led #(
		.SLOT_CYC(STAT_SLOT_CYC),
		.FLASH_CYC(COMM_FLASH_CYC),
		.PULSE_CYC(COMM_PULSE_CYC),
		.HOLD_CYC(CAN_HOLD_CYC)
	) tqo_led_i (
		.i_core_clk(i_core_clk),
		.i_rstn(i_rstn),
		.i_pat(pat),
		.i_usb_active(i_usb_active),
		.i_can_activity(i_can_activity),
		.o_led_stat_grn(o_led_stat_grn),
		.o_led_stat_red(o_led_stat_red),
		.o_led_comm(o_led_comm)
	);

	always_comb
	begin
		ev = '0;
		ev[EV_PASS] = state_r == ST_CHK_ON && state_nxt != ST_FAULT && state_nxt != ST_CHK_ON;
		ev[EV_FAIL] = state_nxt == ST_FAULT && state_r != ST_FAULT;
		ev[EV_TRIP] = state_r == ST_RUN && state_nxt == ST_STOP;
		ev[EV_ARM] = safe_stop_en_r && both_rise;
	end

	// a new event beats a clear in the same cycle
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			irq_stat_r <= '0;
		else if (i_bus.wr && i_bus.addr == ADDR_IRQ_CLR)
			irq_stat_r <= (irq_stat_r & ~i_bus.wdata[EV_W-1:0]) | ev;
		else
			irq_stat_r <= irq_stat_r | ev;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			irq_en_r <= IRQ_EN_RST;
			drive_allow_r <= CTRL_DRIVE_RST;
		end
		else if (i_bus.wr && i_bus.addr == ADDR_IRQ_EN)
			irq_en_r <= i_bus.wdata[EV_W-1:0];
		else if (i_bus.wr && i_bus.addr == ADDR_CTRL)
			drive_allow_r <= i_bus.wdata[CTRL_DRIVE_BIT];
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_irq <= 1'b0;
		else
			o_irq <= |(irq_stat_r & irq_en_r);
	end

	// backup domain: main reset never touches it
	always_ff @(posedge i_core_clk or negedge i_bkp_rstn)
	begin
		if (!i_bkp_rstn)
		begin
			tod_r <= 32'h0;
			user_r <= 32'h0;
			tick_cnt_r <= 32'h0;
		end
		else
		begin
			tick_cnt_r <= (tick_cnt_r == 32'(TOD_TICK_CYC - 1)) ? 32'h0 : tick_cnt_r + 32'h1;
			if (i_bus.wr && i_bus.addr == ADDR_TOD)
				tod_r <= i_bus.wdata;
			else if (tick_cnt_r == 32'(TOD_TICK_CYC - 1))
				tod_r <= tod_r + 32'h1;
			if (i_bus.wr && i_bus.addr == ADDR_USER)
				user_r <= i_bus.wdata;
		end
	end

	always_comb
	begin
		rdata_nxt = 32'h0;
		if (!i_bus.rd)
			rdata_nxt = 32'h0;
		else if (i_bus.addr == ADDR_CTRL)
			rdata_nxt = {31'h0, drive_allow_r};
		else if (i_bus.addr == ADDR_STATE)
			rdata_nxt = {22'h0, fb, sync2_r[SYN_JMP], both, safe_stop_en_r, state_r};
		else if (i_bus.addr == ADDR_IRQ_STAT)
			rdata_nxt = {28'h0, irq_stat_r};
		else if (i_bus.addr == ADDR_IRQ_EN)
			rdata_nxt = {28'h0, irq_en_r};
		else if (i_bus.addr == ADDR_TOD)
			rdata_nxt = tod_r;
		else if (i_bus.addr == ADDR_USER)
			rdata_nxt = user_r;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_rdata <= 32'h0;
		else
			o_rdata <= rdata_nxt;
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rstn);

	stop_gate_off_a: assert property (safe_stop_en_r && !both |=> o_gate_hi == 3'h0 && o_gate_lo == 3'h0)
		else $error("gates driven with a stop input low");
	both_needed_a: assert property (|{o_gate_hi, o_gate_lo} && safe_stop_en_r |-> $past(both))
		else $error("gates driven without both stop inputs");
	float_a: assert property (state_r == ST_STOP |=> o_gate_hi == 3'h0 && o_gate_lo == 3'h0)
		else $error("phase drive during safe stop");
	check_first_a: assert property ($rose(state_r == ST_RUN) |-> $past(state_r) == ST_CHK_ON)
		else $error("run entered without a self-check");
	check_pass_a: assert property (|{o_gate_hi, o_gate_lo} |-> $past(state_r) == ST_RUN)
		else $error("drive while not in run");
	rearm_check_a: assert property (state_r == ST_STOP && both_rise |=> state_r == ST_CHK_OFF ##1 o_chk_pulse)
		else $error("no self-check on re-arm");
	fault_hold_a: assert property (state_r == ST_FAULT |=> {o_gate_hi, o_gate_lo} == 6'h00 && !o_led_stat_grn)
		else $error("fault did not hold outputs off");
	remap_a: assert property (safe_stop_en_r |=> !o_general_input_one && !o_general_input_two)
		else $error("stop inputs leaked to general inputs");
	strap_hold_a: assert property (state_r != ST_BOOT |=> $stable(safe_stop_en_r))
		else $error("safe stop enable changed after boot");
	power_led_a: assert property (state_r != ST_BOOT |-> o_led_power)
		else $error("power indicator off");
	irq_level_a: assert property (|(irq_stat_r & irq_en_r) |=> o_irq)
		else $error("interrupt not raised");

	run_c: cover property (state_r == ST_CHK_ON ##1 state_r == ST_RUN);
	trip_c: cover property (state_r == ST_RUN ##1 state_r == ST_STOP);
	fault_c: cover property (state_r == ST_CHK_ON ##1 state_r == ST_FAULT);
	rearm_c: cover property (state_r == ST_STOP ##1 state_r == ST_CHK_OFF);
endmodule

/* verif/tqo_safety_model.sv */
// Purpose: external safety circuit and interlock path stand-in
// Assumes: stop levels are set by the bench just after a clock edge
// Notes: stuck feedback mimics a welded gate path for the fail case
`timescale 1ns/10ps
module tqo_safety_model (
	input wire logic i_want_a,
	input wire logic i_want_b,
	input wire logic i_stuck_fb,
	input wire logic i_chk_pulse,
	input wire logic i_jumper_fitted,
	output logic o_stop_a,
	output logic o_stop_b,
	output logic o_fb
);
	// both lines high together permit torque
	assign o_stop_a = i_want_a;
	assign o_stop_b = i_want_b;
	// path blocked by check pulse, or by a missing stop input with no jumper fitted, unless stuck
	assign o_fb = i_stuck_fb | (~i_chk_pulse & (i_jumper_fitted | (o_stop_a & o_stop_b)));
endmodule

/* verif/tqo_interlock_bench.sv */
// Purpose: self-checking bench for the torque-off interlock
// Assumes: shortened led and tick counts, check phases of 2000 cycles each
// Notes: reads are checked by a monitor against a queue of expected words
`timescale 1ns/10ps
module tqo_interlock_bench;
	import tqo_pkg::*;
	logic clk, rstn, irq, want_a, want_b, stuck, jmp, fb, pin_a, pin_b, chk, usb, can, can_on;
	logic gin1, gin2, ledp, grn, red, comm, bkp_rstn;
	logic rd_seen = 1'b0;
	tqo_bus_req_s bus;
	logic [31:0] rdata;
	logic [2:0] ph_hi, g_hi, g_lo;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int mismatches, tests_run, n, g, r, c;

	tqo_safety_model tqo_safety_model_i (.i_want_a(want_a), .i_want_b(want_b), .i_stuck_fb(stuck),
		.i_chk_pulse(chk), .i_jumper_fitted(jmp), .o_stop_a(pin_a), .o_stop_b(pin_b), .o_fb(fb));

	tqo_interlock #(.STAT_SLOT_CYC(4), .COMM_FLASH_CYC(16), .COMM_PULSE_CYC(4), .CAN_HOLD_CYC(32),
		.TOD_TICK_CYC(20)) tqo_interlock_i (.i_core_clk(clk), .i_rstn(rstn), .i_bkp_rstn(bkp_rstn),
		.i_bus(bus), .o_rdata(rdata), .o_irq(irq), .i_general_input_one(pin_a),
		.i_general_input_two(pin_b), .i_jumper_fitted(jmp), .i_interlock_fb(fb), .i_phase_hi(ph_hi),
		.i_phase_lo(~ph_hi), .i_usb_active(usb), .i_can_activity(can), .o_gate_hi(g_hi), .o_gate_lo(g_lo),
		.o_chk_pulse(chk), .o_general_input_one(gin1), .o_general_input_two(gin2), .o_led_power(ledp),
		.o_led_stat_grn(grn), .o_led_stat_red(red), .o_led_comm(comm));

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// one-cycle frame pulses every other cycle while traffic is on
	always @(posedge clk)
		can <= can_on & ~can;

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task print_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge clk);
		bus <= '{a, 32'h0, 1'b0, 1'b1};
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge clk);
		bus <= '0;
	endtask

	// wait, then step past the edge so its updates have landed
	task cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task cnt(input int k);
		g = 0;
		r = 0;
		c = 0;
		repeat (k)
		begin
			@(negedge clk);
			g += grn;
			r += red;
			c += comm;
		end
	endtask

	// read word stands only in the cycle after the strobe
	always @(posedge clk)
	begin
		if (rd_seen)
			check("read data", rdata & msk_q.pop_front(), exp_q.pop_front());
		rd_seen <= bus.rd;
	end

	initial
	begin
		#3000000;
		mismatches++;
		print_verdict;
	end

	initial
	begin
		rstn = 1'b0;
		bkp_rstn = 1'b0;
		bus = '0;
		{want_a, want_b} = 2'b11;
		{stuck, jmp, usb, can_on} = '0;
		ph_hi = 3'h0;
		mismatches = 0;
		tests_run = 0;
		n = $urandom(6714);
		repeat (5) @(posedge clk);
		check("power led in reset", ledp, 1'b0);
		rstn <= 1'b1;
		bkp_rstn <= 1'b1;
		rd(ADDR_CTRL, 32'h0, '1);
		rd(ADDR_IRQ_EN, {28'h0, IRQ_EN_RST}, '1);
		rd(8'h1c, 32'h0, '1);
		wr(ADDR_CTRL, 32'h1);
		ph_hi <= 3'($urandom_range(1, 6));
		cyc(100);
		check("power led", ledp, 1'b1);
		check("gates during check", {g_hi, g_lo}, 6'h0);
		cyc(4000);
		rd(ADDR_STATE, 32'h2c0 | 32'(ST_RUN), '1);
		check("general input one", gin1, 1'b0);
		check("general input two", gin2, 1'b0);
		check("gates in run", {g_hi, g_lo}, {ph_hi, ~ph_hi});
		cnt(64);
		check("run green", g, 4);
		check("run red", r, 0);
		rd(ADDR_IRQ_STAT, 32'h1, '1);
		wr(ADDR_IRQ_CLR, 32'hf);
		wr(ADDR_IRQ_EN, 32'h4);
		rd(ADDR_IRQ_STAT, 32'h0, '1);
		rd(ADDR_IRQ_CLR, 32'h0, '1);
		wr(ADDR_STATE, '1);
		rd(ADDR_STATE, 32'h2c0 | 32'(ST_RUN), '1);
		n = $urandom;
		wr(ADDR_USER, n);
		rd(ADDR_USER, n, '1);
		wr(ADDR_TOD, 32'h100);
		rd(ADDR_TOD, 32'h100, 32'hfffffffe);
		want_a <= 1'b0;
		cyc(4);
		check("gates after stop", {g_hi, g_lo}, 6'h0);
		cyc(1);
		check("trip irq", irq, 1'b1);
		rd(ADDR_IRQ_STAT, 32'h4, '1);
		wr(ADDR_IRQ_EN, 32'h0);
		cyc(2);
		check("masked irq", irq, 1'b0);
		wr(ADDR_IRQ_EN, 32'h4);
		cyc(2);
		check("unmasked irq", irq, 1'b1);
		wr(ADDR_IRQ_CLR, 32'h4);
		cyc(2);
		check("cleared irq", irq, 1'b0);
		cnt(64);
		check("stop green", g, 8);
		want_a <= 1'b1;
		cyc(4);
		check("recheck pulse", chk, 1'b1);
		check("gates in recheck", {g_hi, g_lo}, 6'h0);
		cyc(4010);
		check("gates after recheck", {g_hi, g_lo}, {ph_hi, ~ph_hi});
		want_b <= 1'b0;
		cyc(8);
		stuck <= 1'b1;
		want_b <= 1'b1;
		cyc(4010);
		check("gates after failed check", {g_hi, g_lo}, 6'h0);
		rd(ADDR_STATE, 32'(ST_FAULT), 32'h3f);
		rd(ADDR_IRQ_STAT, 32'hf, '1);
		cnt(64);
		check("fault red", r, 12);
		check("fault green", g, 0);
		rstn <= 1'b0;
		{jmp, stuck, want_a, want_b} <= 4'b1000;
		cyc(5);
		rstn <= 1'b1;
		cyc(10);
		rd(ADDR_STATE, 32'h100, 32'h140);
		rd(ADDR_USER, n, '1);
		want_a <= 1'b1;
		cyc(5);
		check("general input one freed", gin1, 1'b1);
		cnt(40);
		check("comm idle", c, 0);
		check("check green", g, 40);
		usb <= 1'b1;
		cyc(3);
		cnt(40);
		check("comm usb", c, 40);
		can_on <= 1'b1;
		cyc(20);
		cnt(32);
		check("comm usb and can", c, 24);
		usb <= 1'b0;
		cyc(3);
		cnt(32);
		check("comm can", c, 8);
		cyc(3);
		print_verdict;
	end
endmodule
